/* rtl/lock_delay_timer.sv */
// Purpose: 0.1 s timebase and delay counter of the interlock.
// Assumes: i_run stays high for as long as the delay must run.
// Notes: Dropping i_run clears both prescaler and count.
`timescale 1ns/1ps
module lock_delay_timer #(
  parameter int TICK_CYCLES = on_lock_pkg::TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [on_lock_pkg::DELAY_W-1:0] i_delay,
  output logic o_expired
);
  import on_lock_pkg::*;

  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

  logic [PRE_W-1:0] pre_q;
  logic [DELAY_W-1:0] cnt_q;
  logic tick;

  assign tick = i_run && (pre_q == PRE_LAST);

  // ************************************************************
  // Prescaler
  // ************************************************************
  // aligned tick start
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_q <= '0;
    end else if (!i_run || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PRE_W'(1);
    end
  end

  // ************************************************************
  // Tick counter
  // ************************************************************
  // count, hold at DELAY_MAX, clear when i_run drops
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (!i_run) begin
      cnt_q <= '0;
    end else if (tick && cnt_q != DELAY_MAX) begin
      cnt_q <= cnt_q + DELAY_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_expired <= 1'b0;
    end else begin
      o_expired <= i_run && (cnt_q >= i_delay);
    end
  end

endmodule

/* rtl/on_lock_pkg.sv */
// Purpose: Shared constants and types of the switch-on interlock monitor.
// Assumes: 125 MHz system clock.
// Notes: Source selector codes are grouped in contiguous ranges.
package on_lock_pkg;

  // ************************************************************
  // Clock and timebase
  // ************************************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam longint TICK_TIME_PS = 64'h0000_0017_4876_E800;
  localparam int TICK_CYCLES = int'(TICK_TIME_PS / CLK_PERIOD_PS);

  // ************************************************************
  // Delay setting, in 0.1 s steps
  // ************************************************************
  localparam int DELAY_W = 12;
  localparam logic [DELAY_W-1:0] DELAY_MAX = 12'hBB8;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 12'h000;

  // ************************************************************
  // Lock source selector
  // ************************************************************
  localparam int SEL_W = 8;
  localparam int BASE_DI_N = 8;
  localparam int EXT_DI_N = 6;
  localparam int CAB_DI_N = 8;
  localparam int CW_W = 16;
  localparam int NET_WORDS = 4;
  localparam logic [SEL_W-1:0] SEL_NONE = 8'h00;
  localparam logic [SEL_W-1:0] SEL_DI_HI = 8'h01;
  localparam logic [SEL_W-1:0] SEL_DI_LO = 8'h09;
  localparam logic [SEL_W-1:0] SEL_EXT_HI = 8'h11;
  localparam logic [SEL_W-1:0] SEL_EXT_LO = 8'h17;
  localparam logic [SEL_W-1:0] SEL_CAB_HI = 8'h1D;
  localparam logic [SEL_W-1:0] SEL_CAB_LO = 8'h25;
  localparam logic [SEL_W-1:0] SEL_TERM = 8'h30;
  localparam logic [SEL_W-1:0] SEL_NET = 8'h40;
  localparam logic [SEL_W-1:0] SEL_NET_END = 8'h80;
  localparam logic [3:0] PROFILE_TOP_BIT = 4'hA;
  localparam logic [3:0] NET_FIRST_BIT = 4'h1;

  // ************************************************************
  // Response modes and monitor states
  // ************************************************************
  typedef enum logic [1:0] {
    resp_warn_only = 2'b00,
    resp_error_only = 2'b01,
    resp_warn_then_error = 2'b10
  } resp_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RUN_DELAY = 3'b001,
    ST_RUN_EXPIRED = 3'b011,
    ST_ERROR = 3'b010,
    ST_STOP_LOCK = 3'b110
  } lock_state_t;

endpackage

/* rtl/switch_on_interlock_monitor.sv */
// Purpose: Switch-on interlock monitor of a motor drive.
// Assumes: All inputs synchronous to i_sys_clk.
// Notes: Error latches until i_err_clear with the lock released.
`timescale 1ns/1ps
module switch_on_interlock_monitor #(
  parameter int TICK_CYCLES = on_lock_pkg::TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [on_lock_pkg::BASE_DI_N-1:0] i_base_di,
  input wire logic [on_lock_pkg::EXT_DI_N-1:0] i_ext_di,
  input wire logic i_ext_fitted,
  input wire logic [on_lock_pkg::CAB_DI_N-1:0] i_cab_di,
  input wire logic i_cab_fitted,
  input wire logic [on_lock_pkg::CW_W-1:0] i_terminal_cw,
  input wire logic [on_lock_pkg::CW_W-1:0] i_serial_cw,
  input wire logic [on_lock_pkg::CW_W-1:0] i_fieldbus_cw,
  input wire logic [on_lock_pkg::CW_W-1:0] i_module_cw,
  input wire logic [on_lock_pkg::CW_W-1:0] i_ethernet_cw,
  input wire logic i_io_profile,
  input wire logic i_running,
  input wire logic [on_lock_pkg::SEL_W-1:0] i_lock_sel,
  input wire logic [1:0] i_resp_mode,
  input wire logic [on_lock_pkg::DELAY_W-1:0] i_delay,
  input wire logic i_err_clear,
  output logic o_freewheel,
  output logic o_lock_warn,
  output logic o_lock_err,
  output logic o_lock_active,
  output logic o_sel_valid,
  output logic o_cfg_access,
  output logic o_delay_running,
  output logic [2:0] o_state
);
  import on_lock_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [CW_W-1:0] net_cw [NET_WORDS];
  logic [SEL_W-1:0] off;
  logic [3:0] bit_idx;
  logic [1:0] word_idx;
  logic sel_valid;
  logic sel_low;
  logic sel_level;
  logic lock;
  logic [DELAY_W-1:0] delay_eff;
  resp_mode_t mode;
  lock_state_t state_q;
  lock_state_t state_d;
  logic timer_run;
  logic expired;
  logic warn_d;
  logic err_d;
  logic free_d;

  assign net_cw[0] = i_serial_cw;
  assign net_cw[1] = i_fieldbus_cw;
  assign net_cw[2] = i_module_cw;
  assign net_cw[3] = i_ethernet_cw;

  // ************************************************************
  // Source decode
  // ************************************************************
  // Unfitted or profile-gated choices decode as not assigned
  always_comb begin
    sel_valid = 1'b0;
    sel_low = 1'b0;
    sel_level = 1'b0;
    off = '0;
    bit_idx = '0;
    word_idx = '0;
    if (i_lock_sel == SEL_NONE) begin
      sel_valid = 1'b0;
    end else if (i_lock_sel < SEL_DI_LO) begin
      off = i_lock_sel - SEL_DI_HI;
      sel_valid = 1'b1;
      sel_level = i_base_di[off[2:0]];
    end else if (i_lock_sel < SEL_EXT_HI) begin
      off = i_lock_sel - SEL_DI_LO;
      sel_valid = 1'b1;
      sel_low = 1'b1;
      sel_level = i_base_di[off[2:0]];
    end else if (i_lock_sel < SEL_EXT_LO) begin
      off = i_lock_sel - SEL_EXT_HI;
      sel_valid = i_ext_fitted;
      sel_level = i_ext_di[off[2:0]];
    end else if (i_lock_sel < SEL_CAB_HI) begin
      off = i_lock_sel - SEL_EXT_LO;
      sel_valid = i_ext_fitted;
      sel_low = 1'b1;
      sel_level = i_ext_di[off[2:0]];
    end else if (i_lock_sel < SEL_CAB_LO) begin
      off = i_lock_sel - SEL_CAB_HI;
      sel_valid = i_cab_fitted;
      sel_level = i_cab_di[off[2:0]];
    end else if (i_lock_sel < SEL_CAB_LO + SEL_W'(CAB_DI_N)) begin
      off = i_lock_sel - SEL_CAB_LO;
      sel_valid = i_cab_fitted;
      sel_low = 1'b1;
      sel_level = i_cab_di[off[2:0]];
    end else if (i_lock_sel >= SEL_TERM && i_lock_sel < SEL_NET) begin
      off = i_lock_sel - SEL_TERM;
      bit_idx = off[3:0];
      sel_valid = i_io_profile || (bit_idx > PROFILE_TOP_BIT);
      sel_level = i_terminal_cw[bit_idx];
    end else if (i_lock_sel >= SEL_NET && i_lock_sel < SEL_NET_END) begin
      off = i_lock_sel - SEL_NET;
      bit_idx = off[3:0];
      word_idx = off[5:4];
      sel_valid = (bit_idx >= NET_FIRST_BIT)
        && (i_io_profile || (bit_idx > PROFILE_TOP_BIT));
      sel_level = net_cw[word_idx][bit_idx];
    end
  end

  // ************************************************************
  // Lock condition and settings
  // ************************************************************
  // polarity of the source
  assign lock = sel_valid && (sel_low ? !sel_level : sel_level);

  assign delay_eff = (i_delay > DELAY_MAX) ? DELAY_MAX : i_delay;

  // Unknown response codes fall back to the default mode
  always_comb begin
    case (i_resp_mode)
      resp_error_only: mode = resp_error_only;
      resp_warn_then_error: mode = resp_warn_then_error;
      default: mode = resp_warn_only;
    endcase
  end

  // ************************************************************
  // Delay timer
  // ************************************************************
  // runs only in the delay state
  assign timer_run = (state_q == ST_RUN_DELAY) && lock && i_running;

  lock_delay_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_run(timer_run),
    .i_delay(delay_eff),
    .o_expired(expired)
  );

  // ************************************************************
  // Monitor state machine
  // ************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (lock && i_running) begin
          state_d = ST_RUN_DELAY;
        end else if (lock) begin
          state_d = ST_STOP_LOCK;
        end
      end
      ST_STOP_LOCK: begin
        if (!lock) begin
          state_d = ST_IDLE;
        end else if (i_running) begin
          state_d = ST_RUN_DELAY;
        end
      end
      ST_RUN_DELAY: begin
        if (!lock) begin
          state_d = ST_IDLE;
        end else if (!i_running) begin
          state_d = ST_STOP_LOCK;
        end else if (expired) begin
          state_d = (mode == resp_warn_only) ? ST_RUN_EXPIRED : ST_ERROR;
        end
      end
      ST_RUN_EXPIRED: begin
        if (!lock) begin
          state_d = ST_IDLE;
        end else if (!i_running) begin
          state_d = ST_STOP_LOCK;
        end
      end
      ST_ERROR: begin
        if (i_err_clear && !lock) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // Output decode from the next state
  // ************************************************************
  always_comb begin
    warn_d = 1'b0;
    err_d = 1'b0;
    free_d = 1'b0;
    case (state_d)
      ST_STOP_LOCK: begin
        free_d = 1'b1;
        warn_d = 1'b1;
      end
      ST_RUN_DELAY: begin
        warn_d = (mode == resp_warn_then_error);
      end
      ST_RUN_EXPIRED: begin
        warn_d = 1'b1;
      end
      ST_ERROR: begin
        err_d = 1'b1;
        free_d = 1'b1;
        warn_d = lock && (mode == resp_warn_then_error);
      end
      default: begin
        warn_d = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Registered outputs
  // ************************************************************
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_freewheel <= 1'b0;
      o_lock_warn <= 1'b0;
      o_lock_err <= 1'b0;
      o_state <= ST_IDLE;
    end else begin
      o_freewheel <= free_d;
      o_lock_warn <= warn_d;
      o_lock_err <= err_d;
      o_state <= state_d;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_lock_active <= 1'b0;
      o_sel_valid <= 1'b0;
      o_cfg_access <= 1'b0;
      o_delay_running <= 1'b0;
    end else begin
      o_lock_active <= lock;
      o_sel_valid <= sel_valid;
      o_cfg_access <= (i_lock_sel != SEL_NONE) && sel_valid;
      o_delay_running <= (state_d == ST_RUN_DELAY);
    end
  end

endmodule

/* testbench/aux_contact_model.sv */
// Purpose: Far side: contact chain and control word sources.
// Assumes: One common level for every contact and word bit.
// Notes: Outputs change just after the clock edge.
`timescale 1ns/1ps
module aux_contact_model (
  input wire logic i_sys_clk,
  input wire logic i_level,
  output logic [on_lock_pkg::BASE_DI_N-1:0] o_base_di,
  output logic [on_lock_pkg::EXT_DI_N-1:0] o_ext_di,
  output logic [on_lock_pkg::CAB_DI_N-1:0] o_cab_di,
  output logic [on_lock_pkg::CW_W-1:0] o_cw
);
  import on_lock_pkg::*;
  always_ff @(posedge i_sys_clk) begin
    o_base_di <= {BASE_DI_N{i_level}};
    o_ext_di <= {EXT_DI_N{i_level}};
    o_cab_di <= {CAB_DI_N{i_level}};
    o_cw <= {CW_W{i_level}};
  end
endmodule

/* testbench/on_lock_monitor_sva.sv */
// Purpose: Port-level assertions of the interlock monitor.
// Assumes: Delay setting held while a delay runs.
// Notes: Bound into every monitor instance.
`timescale 1ns/1ps
module on_lock_monitor_sva #(
  parameter int TICK_CYCLES = on_lock_pkg::TICK_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [on_lock_pkg::BASE_DI_N-1:0] i_base_di,
  input wire logic i_io_profile,
  input wire logic i_running,
  input wire logic [on_lock_pkg::SEL_W-1:0] i_lock_sel,
  input wire logic [1:0] i_resp_mode,
  input wire logic [on_lock_pkg::DELAY_W-1:0] i_delay,
  input wire logic i_err_clear,
  input wire logic o_freewheel,
  input wire logic o_lock_warn,
  input wire logic o_lock_err,
  input wire logic o_lock_active,
  input wire logic o_sel_valid,
  input wire logic o_cfg_access,
  input wire logic o_delay_running,
  input wire logic [2:0] o_state
);
  import on_lock_pkg::*;
  // ************************************************************
  // Cycles spent in the delay state
  // ************************************************************
  logic [31:0] cnt_q;
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= o_delay_running ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ************************************************************
  // Assertions
  // ************************************************************
  chk_high_lock: assert property (
    i_lock_sel == SEL_DI_HI && i_base_di[0] |=> o_lock_active)
    else $error("high level source did not lock");
  chk_low_lock: assert property (
    i_lock_sel == SEL_DI_LO && !i_base_di[0] |=> o_lock_active)
    else $error("low level source did not lock");
  chk_stop_freewheel: assert property (
    o_state == ST_STOP_LOCK |-> o_freewheel && o_lock_warn)
    else $error("stopped lock without freewheel or warning");
  chk_profile_gate: assert property (
    i_lock_sel == SEL_TERM && !i_io_profile |=> !o_sel_valid)
    else $error("low control bit accepted outside profile");
  chk_no_source: assert property (
    i_lock_sel == SEL_NONE |=> !o_lock_active && !o_cfg_access)
    else $error("unassigned source acted");
  chk_warn_wait: assert property (
    o_delay_running && i_resp_mode == 2'd0 |-> !o_lock_warn)
    else $error("warning before delay expiry");
  chk_warn_clears: assert property (
    $fell(o_lock_active) && i_resp_mode != 2'd1 |-> ##[0:1] !o_lock_warn)
    else $error("warning held after lock cleared");
  chk_err_only: assert property (
    o_lock_err && i_resp_mode == 2'd1 |-> !o_lock_warn && o_freewheel)
    else $error("error mode raised warning or kept running");
  chk_err_latch: assert property (
    o_lock_err && !i_err_clear |=> o_lock_err)
    else $error("error dropped without clear");
  chk_warn_now: assert property (
    $rose(o_delay_running) && i_resp_mode == 2'd2 |-> o_lock_warn)
    else $error("warning not raised at once");
  chk_delay_max: assert property (
    o_delay_running
    |-> longint'(cnt_q) <= longint'(i_delay) * TICK_CYCLES + 8)
    else $error("delay ran too long");
  chk_delay_min: assert property (
    $fell(o_delay_running) && o_lock_active && i_running
    |-> longint'(cnt_q) >= longint'(i_delay) * TICK_CYCLES)
    else $error("delay expired early");
  cov_stop: cover property (o_state == ST_STOP_LOCK);
  cov_expired: cover property (o_state == ST_RUN_EXPIRED);
  cov_error: cover property (o_state == ST_ERROR);
endmodule
bind switch_on_interlock_monitor on_lock_monitor_sva #(
  .TICK_CYCLES(TICK_CYCLES)
) u_on_lock_monitor_sva (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_base_di(i_base_di), .i_io_profile(i_io_profile),
  .i_running(i_running), .i_lock_sel(i_lock_sel),
  .i_resp_mode(i_resp_mode), .i_delay(i_delay),
  .i_err_clear(i_err_clear), .o_freewheel(o_freewheel),
  .o_lock_warn(o_lock_warn), .o_lock_err(o_lock_err),
  .o_lock_active(o_lock_active), .o_sel_valid(o_sel_valid),
  .o_cfg_access(o_cfg_access), .o_delay_running(o_delay_running),
  .o_state(o_state));

/* testbench/tb_switch_on_interlock_monitor.sv */
// Purpose: Self-checking bench of the interlock monitor.
// Assumes: Short timebase of four cycles per tick.
// Notes: Selector table: code, lock level, profile, fitted, valid.
`timescale 1ns/1ps
module tb_switch_on_interlock_monitor;
  import on_lock_pkg::*;
  localparam int TICK = 4;
  localparam logic [11:0] SEL_TBL [28] = '{12'h00E, 12'h019, 12'h089,
    12'h091, 12'h101, 12'h11B, 12'h16B, 12'h173, 12'h1C3, 12'h118,
    12'h1DB, 12'h253, 12'h2C3, 12'h250, 12'h2DE, 12'h30D, 12'h308,
    12'h3A8, 12'h3B9, 12'h3F9, 12'h40C, 12'h41D, 12'h418, 12'h4B9,
    12'h5F9, 12'h6AD, 12'h7F9, 12'h80E};
  localparam int DLY [4] = '{3, 0, 2, 1};
  logic i_sys_clk, i_rst, lvl, i_fit, i_io_profile, i_running;
  logic i_err_clear, wo;
  logic [SEL_W-1:0] i_lock_sel;
  logic [1:0] i_resp_mode;
  logic [DELAY_W-1:0] i_delay;
  logic [BASE_DI_N-1:0] base_di;
  logic [EXT_DI_N-1:0] ext_di;
  logic [CAB_DI_N-1:0] cab_di;
  logic [CW_W-1:0] cw;
  logic [11:0] e;
  logic o_freewheel, o_lock_warn, o_lock_err, o_lock_active;
  logic o_sel_valid, o_cfg_access, o_delay_running;
  logic [2:0] o_state;
  int num_errors, cmp_count, n;
  aux_contact_model u_aux_contact_model (.i_sys_clk(i_sys_clk),
    .i_level(lvl), .o_base_di(base_di), .o_ext_di(ext_di),
    .o_cab_di(cab_di), .o_cw(cw));
  switch_on_interlock_monitor #(.TICK_CYCLES(TICK))
  u_switch_on_interlock_monitor (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_base_di(base_di), .i_ext_di(ext_di), .i_ext_fitted(i_fit),
    .i_cab_di(cab_di), .i_cab_fitted(i_fit), .i_terminal_cw(cw),
    .i_serial_cw(cw), .i_fieldbus_cw(cw), .i_module_cw(cw),
    .i_ethernet_cw(cw), .i_io_profile(i_io_profile),
    .i_running(i_running), .i_lock_sel(i_lock_sel),
    .i_resp_mode(i_resp_mode), .i_delay(i_delay),
    .i_err_clear(i_err_clear), .o_freewheel(o_freewheel),
    .o_lock_warn(o_lock_warn), .o_lock_err(o_lock_err),
    .o_lock_active(o_lock_active), .o_sel_valid(o_sel_valid),
    .o_cfg_access(o_cfg_access), .o_delay_running(o_delay_running),
    .o_state(o_state));
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_state(logic [2:0] st, int bound);
    n = 0;
    while (o_state !== st) begin
      @(posedge i_sys_clk);
      #1;
      n++;
      if (n > bound) begin
        num_errors++;
        $display("Error state %h not reached", st);
        tally_and_finish();
      end
    end
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {i_rst, lvl, i_fit, i_io_profile, i_running, i_err_clear} = 6'h21;
    {i_lock_sel, i_resp_mode, i_delay} = '0;
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    i_err_clear <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    check("state", o_state, ST_IDLE);
    check("sel_valid", o_sel_valid, 1'b0);
    foreach (SEL_TBL[k]) begin
      e = SEL_TBL[k];
      for (int p = 0; p < 2; p++) begin
        @(posedge i_sys_clk);
        i_lock_sel <= e[11:4];
        i_io_profile <= e[2];
        i_fit <= e[1];
        lvl <= e[3] ^ p[0];
        repeat (4) @(posedge i_sys_clk);
        #1;
        check("sel_valid", o_sel_valid, e[0]);
        check("cfg_access", o_cfg_access, e[0]);
        check("lock", o_lock_active, e[0] & !p[0]);
        check("freewheel", o_freewheel, e[0] & !p[0]);
        check("stop_warn", o_lock_warn, e[0] & !p[0]);
      end
    end
    @(posedge i_sys_clk);
    {i_lock_sel, i_io_profile, i_fit} <= {SEL_DI_HI, 2'b00};
    // Mode code 3 must behave as the warning-only mode
    for (int m = 0; m < 4; m++) begin
      @(posedge i_sys_clk);
      wo = (m == 0) || (m == 3);
      i_resp_mode <= m[1:0];
      i_delay <= DLY[m][DELAY_W-1:0];
      i_running <= 1'b1;
      lvl <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      lvl <= 1'b1;
      wait_state(ST_RUN_DELAY, 8);
      check("warn_now", o_lock_warn, m == 2);
      check("delay_run", o_delay_running, 1'b1);
      if (m == 0) begin
        repeat (6) @(posedge i_sys_clk);
        lvl <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        lvl <= 1'b1;
        wait_state(ST_RUN_DELAY, 8);
      end
      wait_state(wo ? ST_RUN_EXPIRED : ST_ERROR, 100);
      check("delay", n >= DLY[m] * TICK, 1'b1);
      check("delay_max", n <= DLY[m] * TICK + 3, 1'b1);
      check("delay_done", o_delay_running, 1'b0);
      check("warn", o_lock_warn, m != 1);
      check("err", o_lock_err, !wo);
      check("fw_run", o_freewheel, !wo);
      @(posedge i_sys_clk);
      i_err_clear <= 1'b1;
      @(posedge i_sys_clk);
      i_err_clear <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      #1;
      check("err_held", o_lock_err, !wo);
      @(posedge i_sys_clk);
      lvl <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      #1;
      check("warn_clear", o_lock_warn, 1'b0);
      @(posedge i_sys_clk);
      i_err_clear <= 1'b1;
      @(posedge i_sys_clk);
      i_err_clear <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      #1;
      check("err_clear", o_lock_err, 1'b0);
    end
    tally_and_finish();
  end
endmodule
